/* hw/eight_bit_timer_prescaler.sv */
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "timer_map.svh"

module eight_bit_timer_prescaler (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	// apb slave
	input wire timer_pkg::apb_req_s i_apb,
	output timer_pkg::apb_rsp_s o_apb,
	// core side
	input wire logic i_sleep,
	input wire logic i_wdt_src,
	input wire logic i_wdt_clear,
	// pins
	input wire logic i_ext_count_input,
	input wire logic i_ext_irq_pin,
	// results
	output logic o_irq,
	output logic o_core_irq_req,
	output logic o_wdt_tick,
	output logic o_port_pullup_disable
);

	// ************************************************************
	// helper functions
	// ************************************************************

	// terminal-count mask of the shared prescaler
	function automatic logic [7:0] rate_mask(input logic [2:0] rate, input logic to_wdt);
		logic [8:0] m;
		m = 9'h000;
		if (to_wdt) begin
			m = (9'h001 << rate) - 9'h001;
		end else begin
			m = (9'h002 << rate) - 9'h001;
		end
		return m[7:0];
	endfunction

	// address decode, used for the error answer only; read_word decodes read data itself
	function automatic logic addr_hit(input logic [7:0] a);
		logic hit;
		hit = 1'b0;
		case (a)
			`OFS_CONFIG, `OFS_COUNT, `OFS_INTCTL, `OFS_STATUS, `OFS_MASK: begin
				hit = 1'b1;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
		return hit;
	endfunction

	// ************************************************************
	// state
	// ************************************************************
	timer_pkg::state_s s_r;
	timer_pkg::state_s s_nxt;

	// read data mux of the register file
	function automatic logic [31:0] read_word(input logic [7:0] a, input timer_pkg::state_s st);
		logic [31:0] d;
		d = 32'h0000_0000;
		case (a)
			`OFS_CONFIG: begin
				d[7:0] = st.cfg;
			end
			`OFS_COUNT: begin
				d[7:0] = st.count;
			end
			`OFS_INTCTL: begin
				d[7:0] = st.intctl;
			end
			`OFS_STATUS: begin
				d[1:0] = st.status;
			end
			`OFS_MASK: begin
				d[1:0] = st.mask;
			end
			default: begin
				d = 32'h0000_0000;
			end
		endcase
		return d;
	endfunction

	// ************************************************************
	// next-state logic
	// ************************************************************
	always_comb begin
		logic setup;
		logic acc;
		logic wr;
		logic rd;
		logic [7:0] wdat;
		logic q4;
		logic sample;
		logic pin_edge;
		logic int_edge;
		logic timer_evt;
		logic pre_src;
		logic pre_tc;
		logic pre_out;
		logic to_wdt;
		logic inc;
		logic ovf;
		logic [7:0] msk;
		setup = i_apb.psel & ~i_apb.penable;
		acc = i_apb.psel & i_apb.penable & s_r.rsp.pready;
		wr = acc & i_apb.pwrite & ~s_r.rsp.pslverr;
		rd = acc & ~i_apb.pwrite;
		wdat = i_apb.pwdata[7:0];
		q4 = 1'b0;
		sample = 1'b0;
		pin_edge = 1'b0;
		int_edge = 1'b0;
		timer_evt = 1'b0;
		pre_src = 1'b0;
		pre_tc = 1'b0;
		pre_out = 1'b0;
		to_wdt = s_r.cfg[`CFG_PSA];
		inc = 1'b0;
		ovf = 1'b0;
		msk = 8'h00;
		s_nxt = s_r;

		// two-flop synchronisers; the first flop feeds only the second
		s_nxt.pin_s1 = i_ext_count_input;
		s_nxt.pin_s2 = s_r.pin_s1;
		s_nxt.pin_prev = s_r.pin_s2;
		s_nxt.int_s1 = i_ext_irq_pin;
		s_nxt.int_s2 = s_r.int_s1;
		s_nxt.int_prev = s_r.int_s2;

		// four reference clocks make one instruction cycle, q1..q4
		s_nxt.phase = s_r.phase + 2'd1;
		q4 = (s_r.phase == `PH_Q4);
		// sleep also holds a pending event instead of letting a sample drop it
		sample = ((s_r.phase == `PH_Q2) | q4) & ~i_sleep;

		// counted edge of the count pin
		if (s_r.cfg[`CFG_PIN_EDGE]) begin
			pin_edge = s_r.pin_prev & ~s_r.pin_s2;
		end else begin
			pin_edge = ~s_r.pin_prev & s_r.pin_s2;
		end

		// edge of the external interrupt pin
		if (s_r.cfg[`CFG_IRQ_EDGE]) begin
			int_edge = ~s_r.int_prev & s_r.int_s2;
		end else begin
			int_edge = s_r.int_prev & ~s_r.int_s2;
		end

		// timer source events; neither timer source makes an event while asleep
		if (s_r.cfg[`CFG_SRC_SEL]) begin
			timer_evt = pin_edge & ~i_sleep;
		end else begin
			timer_evt = q4 & ~i_sleep;
		end

		// one prescaler, fed by whichever side owns it
		pre_src = to_wdt ? i_wdt_src : timer_evt;
		msk = rate_mask(s_r.cfg[`CFG_RATE_HI:`CFG_RATE_LO], to_wdt);
		pre_tc = pre_src & ((s_r.pre_cnt & msk) == msk);
		if (pre_src) begin
			s_nxt.pre_cnt = s_r.pre_cnt + 8'h01;
		end
		s_nxt.wdt_tick = to_wdt & pre_tc;

		// bypass when the prescaler belongs to the watchdog
		pre_out = to_wdt ? timer_evt : pre_tc;

		// pending event waits for the next q2 or q4 sample
		s_nxt.pending = (s_r.pending & ~sample) | pre_out;

		// hold-off count after a count write, one step per q4
		if (q4 && (s_r.inhibit != 2'd0)) begin
			s_nxt.inhibit = s_r.inhibit - 2'd1;
		end

		// advance the count; sleep blocks every increment, but a count write still loads it
		inc = sample & s_r.pending & (s_r.inhibit == 2'd0) & ~i_sleep;
		if (inc) begin
			s_nxt.count = s_r.count + 8'h01;
		end
		ovf = inc & (s_r.count == `COUNT_TOP);

		// watchdog clear resets the prescaler only while it owns it
		if (to_wdt && i_wdt_clear) begin
			s_nxt.pre_cnt = 8'h00;
		end

		// ************************************************************
		// register writes
		// ************************************************************
		if (wr) begin
			case (i_apb.paddr)
				`OFS_CONFIG: begin
					s_nxt.cfg = wdat;
				end
				`OFS_COUNT: begin
					// a write wins over an increment in the same cycle
					s_nxt.count = wdat;
					s_nxt.inhibit = `WR_INHIBIT_ICYC;
					s_nxt.pending = 1'b0;
					if (!to_wdt) begin
						s_nxt.pre_cnt = 8'h00;
					end
				end
				`OFS_INTCTL: begin
					s_nxt.intctl = wdat;
				end
				`OFS_MASK: begin
					s_nxt.mask = wdat[1:0];
				end
				default: begin
					s_nxt.cfg = s_nxt.cfg;
				end
			endcase
		end

		// hardware sets flags after the write so a set is never lost
		if (ovf) begin
			s_nxt.intctl[`IC_OVF_FLAG] = 1'b1;
		end
		if (int_edge) begin
			s_nxt.intctl[`IC_EXT_FLAG] = 1'b1;
		end

		// read clears only the bits that were actually returned
		if (rd && (i_apb.paddr == `OFS_STATUS)) begin
			s_nxt.status = s_r.status & ~s_r.rsp.prdata[1:0];
		end
		if (ovf) begin
			s_nxt.status[`ST_OVF] = 1'b1;
		end
		if (int_edge) begin
			s_nxt.status[`ST_EXT] = 1'b1;
		end

		// ************************************************************
		// outputs
		// ************************************************************
		s_nxt.irq = |(s_nxt.status & s_nxt.mask);
		s_nxt.core_req = s_nxt.intctl[`IC_GIE] &
			((s_nxt.intctl[`IC_OVF_IE] & s_nxt.intctl[`IC_OVF_FLAG]) |
			(s_nxt.intctl[`IC_EXT_IE] & s_nxt.intctl[`IC_EXT_FLAG]));
		s_nxt.pullup_dis = s_nxt.cfg[`CFG_PULLUP_DIS];

		// ************************************************************
		// apb answer: fixed one access cycle, data caught at setup
		// ************************************************************
		if (setup) begin
			s_nxt.rsp.pready = 1'b1;
			s_nxt.rsp.pslverr = ~addr_hit(i_apb.paddr);
			s_nxt.rsp.prdata = read_word(i_apb.paddr, s_r);
		end else if (acc) begin
			s_nxt.rsp.pready = 1'b0;
			s_nxt.rsp.pslverr = 1'b0;
		end
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s_r <= '0;
			s_r.cfg <= `CFG_RST;
			s_r.count <= `COUNT_RST;
			s_r.intctl <= `INTCTL_RST;
			s_r.pullup_dis <= 1'b1; // tracks cfg reset value
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state flops
	assign o_apb = s_r.rsp;
	assign o_irq = s_r.irq;
	assign o_core_irq_req = s_r.core_req;
	assign o_wdt_tick = s_r.wdt_tick;
	assign o_port_pullup_disable = s_r.pullup_dis;

endmodule

/* hw/timer_map.svh */
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

// ************************************************************
// register byte offsets on the apb bus
// ************************************************************
`define OFS_CONFIG 8'h00
`define OFS_COUNT 8'h04
`define OFS_INTCTL 8'h08
`define OFS_STATUS 8'h0c
`define OFS_MASK 8'h10

// ************************************************************
// timer_config fields
// ************************************************************
`define CFG_PULLUP_DIS 7
`define CFG_IRQ_EDGE 6
`define CFG_SRC_SEL 5
`define CFG_PIN_EDGE 4
`define CFG_PSA 3
`define CFG_RATE_HI 2
`define CFG_RATE_LO 0

// ************************************************************
// interrupt_control fields
// ************************************************************
`define IC_GIE 7
`define IC_OVF_IE 5
`define IC_EXT_IE 4
`define IC_OVF_FLAG 2
`define IC_EXT_FLAG 1

// ************************************************************
// sticky status and mask fields
// ************************************************************
`define ST_OVF 0
`define ST_EXT 1

// ************************************************************
// reset values and timing counts
// ************************************************************
`define CFG_RST 8'hff
`define INTCTL_RST 8'h00
`define COUNT_RST 8'h00
`define COUNT_TOP 8'hff
`define WR_INHIBIT_ICYC 2'd2
`define PH_Q2 2'd1
`define PH_Q4 2'd3

`endif

/* hw/timer_pkg.sv */
package timer_pkg;

	// apb request as seen by the slave
	typedef struct packed {
		logic [7:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} apb_req_s;

	// apb answer, driven from flops
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_s;

	// whole state of the timer block
	typedef struct packed {
		logic [7:0] cfg;
		logic [7:0] count;
		logic [7:0] intctl;
		logic [1:0] status;
		logic [1:0] mask;
		logic [7:0] pre_cnt;
		logic [1:0] phase;
		logic [1:0] inhibit;
		logic pending;
		logic pin_s1;
		logic pin_s2;
		logic pin_prev;
		logic int_s1;
		logic int_s2;
		logic int_prev;
		apb_rsp_s rsp;
		logic irq;
		logic core_req;
		logic wdt_tick;
		logic pullup_dis;
	} state_s;

endpackage

/* sim/eight_bit_timer_prescaler_tb.sv */
`timescale 1ns/1ps
// ***
// timer bench
// ***
module eight_bit_timer_prescaler_tb;
	logic i_ref_clk, i_arst_n, i_sleep, i_wdt_src, i_wdt_clear, i_ext_irq_pin, pin;
	logic o_irq, o_core_irq_req, o_wdt_tick, o_pud, err;
	timer_pkg::apb_req_s i_apb;
	timer_pkg::apb_rsp_s o_apb;
	logic [31:0] rd;
	logic [7:0] v0;
	int num_errors = 0, total_checks = 0, cyc = 0, ticks = 0;
	// config, window in clocks, increments in the window
	logic [31:0] rows[9] = '{32'h0800280a, 32'h00001803, 32'h01003003, 32'h02006003,
		32'h0300c003, 32'h04018003, 32'h05030003, 32'h06060003, 32'h070c0003};
	eight_bit_timer_prescaler i_dut (.i_ref_clk, .i_arst_n, .i_apb, .o_apb, .i_sleep,
		.i_wdt_src, .i_wdt_clear, .i_ext_count_input(pin), .i_ext_irq_pin, .o_irq,
		.o_core_irq_req, .o_wdt_tick, .o_port_pullup_disable(o_pud));
	ext_pin_model i_pin (.i_clk(i_ref_clk), .o_pin(pin));
	// clock
	initial begin
		i_ref_clk = 1'b0;
		forever #20 i_ref_clk = ~i_ref_clk;
	end
	// hang guard and a running count of watchdog ticks
	always @(posedge i_ref_clk) begin
		cyc <= cyc + 1;
		ticks <= ticks + int'(o_wdt_tick === 1'b1);
		if (cyc == 12000) begin
			num_errors++;
			close_out();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one apb transfer; answer taken at the rising edge that sees pready high
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		i_apb <= '{a, 1'b1, 1'b0, w, d};
		@(posedge i_ref_clk);
		i_apb.penable <= 1'b1;
		do @(posedge i_ref_clk); while (o_apb.pready !== 1'b1);
		rd = o_apb.prdata;
		err = o_apb.pslverr;
		{i_apb.psel, i_apb.penable} <= 2'b00;
		// one idle edge so a following call never drives psel twice at once
		@(posedge i_ref_clk);
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// reset, rate table, then the awkward cases
	initial begin
		i_apb = '0;
		{i_sleep, i_wdt_src, i_wdt_clear, i_ext_irq_pin} = 4'h0;
		i_arst_n = 1'b0;
		repeat (8) @(posedge i_ref_clk);
		i_arst_n <= 1'b1;
		@(posedge i_ref_clk);
		for (int i = 0; i < 5; i++) begin
			xfer(8'(i * 4), 1'b0, 32'h0);
			chk(rd, i ? 32'h0 : 32'hff);
		end
		xfer(8'h14, 1'b0, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		chk(o_pud, 1'b1);
		$display("reset test done");
		foreach (rows[r]) begin
			xfer(8'h00, 1'b1, {24'h0, rows[r][31:24]});
			repeat (8) @(posedge i_ref_clk);
			xfer(8'h04, 1'b0, 32'h0);
			v0 = rd[7:0];
			repeat (rows[r][23:8] - 3) @(posedge i_ref_clk);
			xfer(8'h04, 1'b0, 32'h0);
			chk(8'(rd[7:0] - v0), rows[r][7:0]);
		end
		chk(o_pud, 1'b0);
		$display("rate table done");
		// rising edges first, then falling edges only
		xfer(8'h00, 1'b1, 32'h28);
		for (int e = 0; e < 2; e++) begin
			xfer(8'h04, 1'b0, 32'h0);
			v0 = rd[7:0];
			i_pin.toggle(4 - e);
			repeat (16) @(posedge i_ref_clk);
			xfer(8'h04, 1'b0, 32'h0);
			chk(8'(rd[7:0] - v0), 2 - e);
			xfer(8'h00, 1'b1, 32'h38);
		end
		$display("counter mode done");
		// a count write costs two instruction cycles of the forty clocks
		xfer(8'h00, 1'b1, 32'h08);
		xfer(8'h04, 1'b1, 32'h0);
		repeat (38) @(posedge i_ref_clk);
		xfer(8'h04, 1'b0, 32'h0);
		chk(rd[7:0] > 7 && rd[7:0] < 10, 1'b1);
		$display("write hold-off done");
		// overflow and pin flags with the status mask closed, then opened
		xfer(8'h10, 1'b1, 32'h0);
		xfer(8'h08, 1'b1, 32'ha0);
		xfer(8'h00, 1'b1, 32'h48);
		i_ext_irq_pin <= 1'b1;
		xfer(8'h04, 1'b1, 32'hff);
		repeat (20) @(posedge i_ref_clk);
		chk({o_irq, o_core_irq_req}, 2'b01);
		xfer(8'h08, 1'b0, 32'h0);
		chk(rd, 32'ha6);
		xfer(8'h10, 1'b1, 32'h3);
		repeat (2) @(posedge i_ref_clk);
		chk(o_irq, 1'b1);
		xfer(8'h0c, 1'b0, 32'h0);
		chk(rd, 32'h3);
		repeat (2) @(posedge i_ref_clk);
		chk({o_irq, o_core_irq_req}, 2'b01);
		xfer(8'h08, 1'b1, 32'ha0);
		repeat (2) @(posedge i_ref_clk);
		chk(o_core_irq_req, 1'b0);
		$display("interrupt test done");
		// count frozen while asleep
		i_sleep <= 1'b1;
		xfer(8'h04, 1'b0, 32'h0);
		v0 = rd[7:0];
		repeat (40) @(posedge i_ref_clk);
		xfer(8'h04, 1'b0, 32'h0);
		chk(rd[7:0], v0);
		i_sleep <= 1'b0;
		// watchdog at 1:4: six pulses, clear, three more give one tick
		xfer(8'h00, 1'b1, 32'h0a);
		v0 = ticks[7:0];
		for (int k = 0; k < 11; k++) begin
			i_wdt_src <= k inside {[1:6], [8:10]};
			i_wdt_clear <= k == 0 || k == 7;
			@(posedge i_ref_clk);
			{i_wdt_src, i_wdt_clear} <= 2'b00;
			@(posedge i_ref_clk);
		end
		repeat (4) @(posedge i_ref_clk);
		chk(8'(ticks[7:0] - v0), 8'h1);
		$display("sleep and watchdog done");
		// a count write empties the 1:256 timer prescaler; falling irq edge
		xfer(8'h00, 1'b1, 32'h07);
		i_ext_irq_pin <= 1'b0;
		xfer(8'h04, 1'b1, 32'h0);
		repeat (990) @(posedge i_ref_clk);
		xfer(8'h04, 1'b0, 32'h0);
		chk(rd, 32'h0);
		repeat (60) @(posedge i_ref_clk);
		xfer(8'h04, 1'b0, 32'h0);
		chk(rd, 32'h1);
		xfer(8'h08, 1'b0, 32'h0);
		chk(rd, 32'ha2);
		$display("prescaler clear done");
		close_out();
	end
endmodule
bind eight_bit_timer_prescaler timer_checker i_chk (.i_ref_clk, .i_arst_n, .i_apb, .o_apb,
	.i_wdt_src, .o_irq, .o_core_irq_req, .o_wdt_tick, .o_port_pullup_disable);

/* sim/ext_pin_model.sv */
`timescale 1ns/1ps
// ***
// count pin source
// ***
module ext_pin_model (
	// clock
	input wire logic i_clk,
	// pin
	output logic o_pin
);
	// pin idles low
	initial begin
		o_pin = 1'b0;
	end
	// wide spacing so the q2/q4 sampling never merges two edges
	task automatic toggle(input int n);
		for (int k = 0; k < n; k++) begin
			repeat (8) @(posedge i_clk);
			o_pin <= ~o_pin;
		end
	endtask
endmodule

/* sim/timer_properties.sv */
`timescale 1ns/1ps
// ***
// port checks
// ***
module timer_checker (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	// watched ports
	input wire timer_pkg::apb_req_s i_apb,
	input wire timer_pkg::apb_rsp_s o_apb,
	input wire logic i_wdt_src,
	input wire logic o_irq,
	input wire logic o_core_irq_req,
	input wire logic o_wdt_tick,
	input wire logic o_port_pullup_disable
);
	// one domain, so clock and reset are given once
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_arst_n);
	// zero wait states: every setup is answered next cycle
	property p_rdy; i_apb.psel && !i_apb.penable |=> o_apb.pready; endproperty
	a_rdy: assert property (p_rdy) else $error("ready missing");
	property p_one; o_apb.pready |=> !o_apb.pready; endproperty
	a_one: assert property (p_one) else $error("ready too long");
	property p_err; o_apb.pslverr |-> o_apb.pready && o_apb.prdata == 32'h0; endproperty
	a_err: assert property (p_err) else $error("bad error answer");
	property p_hi; o_apb.pready |-> o_apb.prdata[31:8] == 24'h0; endproperty
	a_hi: assert property (p_hi) else $error("upper read bits set");
	// pull-ups leave reset disabled and follow the config write
	property p_rst; $rose(i_arst_n) |-> o_port_pullup_disable; endproperty
	a_rst: assert property (p_rst) else $error("pull-up reset");
	property p_pud; i_apb.psel && i_apb.penable && o_apb.pready && i_apb.pwrite
		&& i_apb.paddr == 8'h00 |-> ##2 o_port_pullup_disable == $past(i_apb.pwdata[7], 2);
	endproperty
	a_pud: assert property (p_pud) else $error("pull-up value");
	// a watchdog tick always follows a watchdog source pulse
	property p_tick; o_wdt_tick |-> $past(i_wdt_src) || $past(i_wdt_src, 2); endproperty
	a_tick: assert property (p_tick) else $error("stray tick");
	// requests only drop after software touched a register
	property p_irqf; $fell(o_irq) |-> $past(i_apb.penable) || $past(i_apb.penable, 2); endproperty
	a_irqf: assert property (p_irqf) else $error("irq dropped");
	property p_reqf; $fell(o_core_irq_req)
		|-> $past(i_apb.pwrite && i_apb.penable) || $past(i_apb.pwrite && i_apb.penable, 2);
	endproperty
	a_reqf: assert property (p_reqf) else $error("request dropped");
endmodule
